// ===== design/rca_pkg.sv
package rca_pkg;
  // byte addresses inside the clock/control space
  localparam logic [7:0] RCA_ADDR_ALM0 = 8'h00;
  localparam logic [7:0] RCA_ADDR_ALM1 = 8'h08;
  localparam logic [7:0] RCA_ADDR_CTL_LO = 8'h10;
  localparam logic [7:0] RCA_ADDR_CTL_HI = 8'h14;
  localparam logic [7:0] RCA_ADDR_PWR = 8'h14;
  localparam logic [7:0] RCA_ADDR_DTR = 8'h13;
  localparam logic [7:0] RCA_ADDR_ATR = 8'h12;
  localparam logic [7:0] RCA_ADDR_ID_LO = 8'h20;
  localparam logic [7:0] RCA_ADDR_ID_HI = 8'h27;
  localparam logic [7:0] RCA_ADDR_RTC_LO = 8'h30;
  localparam logic [7:0] RCA_ADDR_RTC_HI = 8'h37;
  localparam logic [7:0] RCA_ADDR_STATUS = 8'h3F;
  // device-select byte and status commands
  localparam logic [7:0] RCA_SEL_CCR = 8'hDE;
  localparam logic [7:0] RCA_CMD_WEL = 8'h02;
  localparam logic [7:0] RCA_CMD_REGISTER_WRITE_LATCH = 8'h06;
  localparam logic [7:0] RCA_CMD_CLEAR = 8'h00;
  // status byte fields
  localparam int RCA_ST_AL0 = 5;
  localparam int RCA_ST_AL1 = 6;
  localparam int RCA_ST_REGISTER_WRITE_LATCH = 2;
  localparam int RCA_ST_WEL = 1;
  // power byte fields and reset values
  localparam int RCA_PWR_BACKUP_BUS_DISABLE = 7;
  localparam int RCA_PWR_BSW = 6;
  localparam logic [7:0] RCA_PWR_RESET = 8'h40;
  localparam logic [7:0] RCA_ATR_RESET = 8'h00;
  localparam logic [7:0] RCA_DTR_RESET = 8'h00;
  // interrupt control byte (alarm mode) in control space
  localparam logic [7:0] RCA_ADDR_INT = 8'h11;
  localparam int RCA_INT_IM = 7;
  localparam int RCA_INT_ALARM_ONE_ENABLE = 6;
  localparam int RCA_INT_ALARM_ZERO_ENABLE = 5;
  localparam int RCA_INT_FO = 0;
  // programming time
  localparam int RCA_CLK_HZ = 50000000;
  localparam int RCA_PROG_MS = 20;
  localparam int RCA_PROG_CYC = RCA_CLK_HZ / 1000 * RCA_PROG_MS;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } rca_byte_type;

  typedef enum logic [4:0] {
    RCA_IDLE = 5'b00001,
    RCA_DEVSEL = 5'b00010,
    RCA_ADDR = 5'b00100,
    RCA_WDATA = 5'b01000,
    RCA_RDATA = 5'b10000
  } rca_state_type;
endpackage : rca_pkg

// ===== design/rca_control.sv
`timescale 1ns/10ps
// What this block does
// RL1 - digital trim top bit is sign, zero magnitude means no correction
// RL2 - trim magnitude bits give ten and twenty ppm, up to thirty
// RL3 - analog trim drives two cap banks, top bit weight applied when clear
// RL4 - backup bus-disable bit blocks serial bus on battery, resets zero
// RL5 - supply-switch policy zero standard, one legacy, legacy default
// RL6 - three-bit reset-level select chooses supply threshold code
// RL7 - reset-level select protected by register-write latch, accepted writes persist
// RL8 - unique id readable at 20h to 27h, writes never change it
// RL9 - status write 02h sets write-enable latch at once
// RL10 - status write 06h sets both latches when write-enable latch already set
// RL11 - host sends select byte, address, data bytes, then stop
// RL12 - control byte writes start up to 20ms program cycle
// RL13 - writes to undefined clock/control addresses are discarded
// RL14 - completed clock/control write clears register-write latch
// RL15 - aborted clock/control write leaves register-write latch set
// RL16 - status write of zero clears both latches
// RL17 - read between sequence steps does not disturb pending write
// RL18 - two alarm flags set when enabled fields match time
// RL19 - alarm flags clear on eighth falling clock of status read
// RL20 - single mode flags one match only, both alarms may run
// RL21 - repeat mode flags every match until mode or enables cleared
// RL22 - repeat with both enables: only alarm zero repeats
// RL23 - alarm byte top bit is field compare enable, no year field
// RL24 - clock/control writes refused while register-write latch clear
module rca_control
  import rca_pkg::*;
#(
  parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF, // arbitrary value
  parameter int PROG_CYCLES = RCA_PROG_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic onBattery,
  input wire logic [55:0] rtcTime,
  output logic [5:0] analogTrimCode,
  output logic [2:0] digitalTrim,
  output logic backupBusDisable,
  output logic supplySwitchPolicy,
  output logic [2:0] resetThreshold,
  output logic progBusy,
  output logic [55:0] rtcWrite,
  output logic rtcWriteStrobe
);
  logic [1:0] sclSync_q, sdaSync_q;
  logic sclPrev_q, sdaPrev_q;
  rca_state_type state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q, addr_q, txByte_q;
  logic isWrite_q, ackPhase_q, ccrSel_q, wroteCcr_q, statusRead_q, aborted_q;
  logic [7:0] alarm_q [16];
  logic [7:0] intCtl_q, atr_q, dtr_q, pwr_q;
  logic [55:0] rtcBuf_q;
  logic wel_q, register_write_latch_q, al0_q, al1_q, al0Done_q, al1Done_q;
  logic [31:0] progCnt_q;
  logic sdaOut_q, sdaOe_q, strobe_q;
  logic [7:0] wrCount_q;
  logic [55:0] prevTime_q;
  logic [1:0] batSync_q;
  logic mAck_q;

  wire scl = sclSync_q[1];
  wire sda = sdaSync_q[1];
  wire sclRise = scl & ~sclPrev_q;
  wire sclFall = ~scl & sclPrev_q;
  wire startCond = scl & sclPrev_q & sdaPrev_q & ~sda;
  wire stopCond = scl & sclPrev_q & ~sdaPrev_q & sda;
  // backup disable
  // RL4 bus gate
  wire busOff = pwr_q[RCA_PWR_BACKUP_BUS_DISABLE] & batSync_q[1];

  function automatic logic inRange(input logic [7:0] a, input logic [7:0] lo,
                                   input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : inRange

  // RL13 address map
  wire addrAlarm = inRange(addr_q, RCA_ADDR_ALM0, 8'h0F);
  wire addrCtl = inRange(addr_q, RCA_ADDR_CTL_LO, RCA_ADDR_CTL_HI);
  wire addrRtc = inRange(addr_q, RCA_ADDR_RTC_LO, RCA_ADDR_RTC_HI);
  wire addrId = inRange(addr_q, RCA_ADDR_ID_LO, RCA_ADDR_ID_HI);
  wire addrSt = addr_q == RCA_ADDR_STATUS;
  wire [2:0] idIdx = addr_q[2:0];
  wire [2:0] rtcIdx = addr_q[2:0];
  // RL24 latch gate
  wire ccrWrOk = register_write_latch_q & (progCnt_q == 32'd0);
  wire byteDone = sclFall & (bitCnt_q == 4'd8) & ~ackPhase_q;
  wire [7:0] rdByte = addrSt ? {1'b0, al1_q, al0_q, 2'b00, register_write_latch_q, wel_q, 1'b0} :
                      addrId ? UNIQUE_ID[{idIdx, 3'b000} +: 8] :
                      (addrRtc && rtcIdx != 3'd7) ? rtcTime[{rtcIdx, 3'b000} +: 8] :
                      addrAlarm ? alarm_q[addr_q[3:0]] :
                      (addr_q == RCA_ADDR_INT) ? intCtl_q :
                      (addr_q == RCA_ADDR_ATR) ? atr_q :
                      (addr_q == RCA_ADDR_DTR) ? dtr_q :
                      (addr_q == RCA_ADDR_PWR) ? pwr_q : 8'h00;

  // RL23 field match
  function automatic logic alarmHit(input logic [7:0] a [16], input int base,
                                    input logic [55:0] t);
    logic hit;
    logic any;
    hit = 1'b1;
    any = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (i != 5 && a[base+i][7]) begin
        any = 1'b1;
        if (a[base+i][6:0] != t[i*8 +: 7]) hit = 1'b0;
      end
    end
    return hit & any;
  endfunction : alarmHit

  wire tick = rtcTime != prevTime_q;
  wire match0 = tick & alarmHit(alarm_q, 0, rtcTime);
  wire match1 = tick & alarmHit(alarm_q, 8, rtcTime);
  wire repeatMode = intCtl_q[RCA_INT_IM];
  wire en0 = intCtl_q[RCA_INT_ALARM_ZERO_ENABLE] & ~intCtl_q[RCA_INT_FO];
  // RL22 alarm zero priority
  wire en1 = intCtl_q[RCA_INT_ALARM_ONE_ENABLE] & ~intCtl_q[RCA_INT_FO] & ~(repeatMode & en0);
  // RL20 single shot
  // RL21 repeat every match
  wire set0 = match0 & en0 & (repeatMode | ~al0Done_q);
  wire set1 = match1 & en1 & (repeatMode | ~al1Done_q);
  // RL19 read clear on eighth fall
  wire clrAl = byteDone & ~isWrite_q & statusRead_q & (state_q == RCA_RDATA);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sclSync_q <= 2'b11;
      sdaSync_q <= 2'b11;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      prevTime_q <= '0;
      batSync_q <= 2'b00;
    end else begin
      batSync_q <= {batSync_q[0], onBattery};
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= scl;
      sdaPrev_q <= sda;
      prevTime_q <= rtcTime;
    end
  end

  // RL18 alarm flags
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      al0_q <= 1'b0;
      al1_q <= 1'b0;
      al0Done_q <= 1'b0;
      al1Done_q <= 1'b0;
    end else begin
      al0_q <= set0 | (al0_q & ~clrAl);
      al1_q <= set1 | (al1_q & ~clrAl);
      al0Done_q <= (al0Done_q | set0) & en0;
      al1Done_q <= (al1Done_q | set1) & en1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= RCA_IDLE;
      bitCnt_q <= 4'd0;
      shift_q <= 8'h00;
      addr_q <= 8'h00;
      txByte_q <= 8'h00;
      isWrite_q <= 1'b0;
      ackPhase_q <= 1'b0;
      ccrSel_q <= 1'b0;
      wroteCcr_q <= 1'b0;
      statusRead_q <= 1'b0;
      aborted_q <= 1'b0;
      mAck_q <= 1'b0;
      sdaOut_q <= 1'b1;
      sdaOe_q <= 1'b1;
      wel_q <= 1'b0;
      register_write_latch_q <= 1'b0;
      intCtl_q <= 8'h00;
      atr_q <= RCA_ATR_RESET;
      dtr_q <= RCA_DTR_RESET;
      pwr_q <= RCA_PWR_RESET;
      rtcBuf_q <= '0;
      strobe_q <= 1'b0;
      progCnt_q <= 32'd0;
      wrCount_q <= 8'd0;
      for (int i = 0; i < 16; i++) alarm_q[i] <= 8'h00;
    end else begin
      strobe_q <= 1'b0;
      // RL12 program cycle
      if (progCnt_q != 32'd0) progCnt_q <= progCnt_q - 32'd1;
      if (busOff) begin
        state_q <= RCA_IDLE;
        sdaOe_q <= 1'b1;
      end else if (startCond) begin
        // RL15 abort keeps latch
        state_q <= RCA_DEVSEL;
        bitCnt_q <= 4'd0;
        ackPhase_q <= 1'b0;
        sdaOe_q <= 1'b1;
        wroteCcr_q <= 1'b0;
      end else if (stopCond) begin
        // RL14 complete clears latch
        if (wroteCcr_q && !aborted_q) begin
          register_write_latch_q <= 1'b0;
          if (addrRtc || rtcBuf_q != rtcTime) strobe_q <= wrCount_q == 8'd8;
        end
        state_q <= RCA_IDLE;
        wroteCcr_q <= 1'b0;
        sdaOe_q <= 1'b1;
      end else if (state_q != RCA_IDLE) begin
        if (sclRise && !ackPhase_q) begin
          shift_q <= {shift_q[6:0], sda};
          bitCnt_q <= bitCnt_q + 4'd1;
        end
        if (sclRise && ackPhase_q) mAck_q <= ~sda;
        if (sclFall && ackPhase_q) begin
          ackPhase_q <= 1'b0;
          bitCnt_q <= 4'd0;
          sdaOe_q <= 1'b1;
          if (state_q == RCA_RDATA && !isWrite_q) begin
            // a master nack ends the read, else a low data bit would block the stop
            if (mAck_q) begin
              txByte_q <= rdByte;
              sdaOut_q <= rdByte[7];
              sdaOe_q <= rdByte[7];
            end else begin
              state_q <= RCA_IDLE;
            end
          end
        end else if (sclFall && state_q == RCA_RDATA && !ackPhase_q && bitCnt_q < 4'd8) begin
          sdaOe_q <= txByte_q[3'd7 - bitCnt_q[2:0]];
        end
        if (byteDone) begin
          ackPhase_q <= 1'b1;
          unique case (state_q)
            RCA_DEVSEL: begin
              ccrSel_q <= shift_q[7:1] == RCA_SEL_CCR[7:1];
              isWrite_q <= ~shift_q[0];
              sdaOe_q <= ~(shift_q[7:1] == RCA_SEL_CCR[7:1]);
              state_q <= (shift_q[7:1] != RCA_SEL_CCR[7:1]) ? RCA_IDLE :
                         shift_q[0] ? RCA_RDATA : RCA_ADDR;
              statusRead_q <= addrSt;
              if (shift_q[0]) begin
                txByte_q <= rdByte;
              end
            end
            RCA_ADDR: begin
              addr_q <= shift_q;
              sdaOe_q <= 1'b0;
              state_q <= RCA_WDATA;
              wrCount_q <= 8'd0;
              aborted_q <= 1'b0;
            end
            RCA_WDATA: begin
              sdaOe_q <= 1'b0;
              addr_q <= addr_q + 8'd1;
              wrCount_q <= wrCount_q + 8'd1;
              if (addrSt) begin
                // RL9 set write enable
                // RL10 set both latches
                // RL16 clear both
                if (shift_q == RCA_CMD_WEL) wel_q <= 1'b1;
                else if (shift_q == RCA_CMD_REGISTER_WRITE_LATCH && wel_q) begin
                  wel_q <= 1'b1;
                  register_write_latch_q <= 1'b1;
                end else if (shift_q == RCA_CMD_CLEAR) begin
                  wel_q <= 1'b0;
                  register_write_latch_q <= 1'b0;
                end
              end else if (ccrWrOk) begin
                wroteCcr_q <= 1'b1;
                // RL8 id is read only
                if (addrAlarm) begin
                  alarm_q[addr_q[3:0]] <= shift_q;
                  progCnt_q <= 32'(PROG_CYCLES);
                end else if (addr_q == RCA_ADDR_INT) begin
                  intCtl_q <= shift_q;
                  progCnt_q <= 32'(PROG_CYCLES);
                end else if (addr_q == RCA_ADDR_ATR) begin
                  atr_q <= shift_q;
                  progCnt_q <= 32'(PROG_CYCLES);
                end else if (addr_q == RCA_ADDR_DTR) begin
                  dtr_q <= shift_q;
                  progCnt_q <= 32'(PROG_CYCLES);
                end else if (addr_q == RCA_ADDR_PWR) begin
                  // RL7 latch-protected threshold
                  pwr_q <= shift_q;
                  progCnt_q <= 32'(PROG_CYCLES);
                end else if (addrRtc && rtcIdx != 3'd7) begin
                  rtcBuf_q[{rtcIdx, 3'b000} +: 8] <= shift_q;
                end
              end
            end
            RCA_RDATA: begin
              // RL17 read leaves latches
              sdaOe_q <= 1'b1;
              addr_q <= addr_q + 8'd1;
            end
            default: state_q <= RCA_IDLE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      analogTrimCode <= 6'h00;
      digitalTrim <= 3'h0;
      backupBusDisable <= 1'b0;
      supplySwitchPolicy <= 1'b1;
      resetThreshold <= 3'h0;
      progBusy <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b1;
      rtcWrite <= '0;
      rtcWriteStrobe <= 1'b0;
    end else begin
      // RL3 capacitor banks
      analogTrimCode <= atr_q[5:0];
      // RL1 sign bit
      // RL2 ppm magnitude
      digitalTrim <= dtr_q[2:0];
      backupBusDisable <= pwr_q[RCA_PWR_BACKUP_BUS_DISABLE];
      // RL5 switch policy
      supplySwitchPolicy <= pwr_q[RCA_PWR_BSW];
      // RL6 level select
      resetThreshold <= pwr_q[2:0];
      progBusy <= progCnt_q != 32'd0;
      sdaOut <= 1'b0;
      sdaOe <= sdaOe_q;
      rtcWrite <= rtcBuf_q;
      // RL11 clock bytes commit
      rtcWriteStrobe <= strobe_q;
    end
  end

  // RL14 latch cleared
  register_write_latch_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (stopCond && !busOff && wroteCcr_q && !aborted_q) |=> !register_write_latch_q) // RL14
    else $error("register latch not cleared");
  // RL24 refused write
  refuse_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !register_write_latch_q && !startCond && !stopCond |=> $stable(atr_q) && $stable(pwr_q)) // RL24
    else $error("write taken without latch");
  // RL12 program time
  prog_busy_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(progCnt_q != 32'd0) |-> progCnt_q == 32'(PROG_CYCLES)) // RL12
    else $error("program count wrong");
  // RL19 flag clear
  alarm_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    clrAl && !set0 |=> !al0_q) // RL19
    else $error("alarm zero not cleared");
  // RL22 priority
  alarm_prio_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    repeatMode && en0 |-> !set1) // RL22
    else $error("alarm one repeats");
  // RL20 one shot
  single_shot_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !repeatMode && al0Done_q |-> !set0) // RL20
    else $error("single alarm fired twice");
  // RL4 bus gate
  bus_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    busOff |=> state_q == RCA_IDLE && sdaOe_q) // RL4
    else $error("bus active on battery");
  // RL16 clear both
  status_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    byteDone && state_q == RCA_WDATA && addrSt && shift_q == RCA_CMD_CLEAR && !busOff
    && !startCond && !stopCond |=> !wel_q && !register_write_latch_q) // RL16
    else $error("latches not cleared");
endmodule : rca_control

// ===== sim/rca_host.sv
`timescale 1ns/10ps
module rca_host (
  input wire logic clk,
  input wire logic sdaBus,
  output logic scl = 1'b1,
  output logic sdaDrv = 1'b1
);
  task automatic hw(input int n);
    repeat (n) @(posedge clk);
  endtask : hw
  task automatic start();
    sdaDrv <= 1'b1;
    hw(2);
    scl <= 1'b1;
    hw(4);
    sdaDrv <= 1'b0;
    hw(4);
    scl <= 1'b0;
    hw(2);
  endtask : start
  task automatic stop();
    sdaDrv <= 1'b0;
    hw(2);
    scl <= 1'b1;
    hw(4);
    sdaDrv <= 1'b1;
    hw(4);
  endtask : stop
  // data moves mid-low so the sync delay never sees it near a rise
  task automatic bitx(input logic b, output logic r);
    sdaDrv <= b;
    hw(2);
    scl <= 1'b1;
    hw(4);
    r = sdaBus;
    scl <= 1'b0;
    hw(2);
  endtask : bitx
  // msb first, ninth bit released
  task automatic xfer(input logic [7:0] t, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bitx(t[i], r[i]);
    end
    bitx(1'b1, a);
  endtask : xfer
endmodule : rca_host

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import rca_pkg::*;
  localparam logic [63:0] UID = 64'hA5C31E2D4B6F7081; // arbitrary value
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic onBattery = 1'b0;
  logic [55:0] rtcTime = '0;
  logic [7:0] rx;
  logic ak;
  int j;
  int n_errors = 0;
  int checks_done = 0;
  wire logic scl, sdaDrv, sdaOut, sdaOe, progBusy, rtcWriteStrobe;
  wire logic backupBusDisable, supplySwitchPolicy;
  wire logic [5:0] analogTrimCode;
  wire logic [2:0] digitalTrim, resetThreshold;
  wire logic [55:0] rtcWrite;
  wire logic sdaBus = sdaDrv & (sdaOe | sdaOut);
  wire logic [13:0] outs = {analogTrimCode, digitalTrim, backupBusDisable,
    supplySwitchPolicy, resetThreshold};
  logic [7:0] ra [8] = '{8'h12, 8'h12, 8'h13, 8'h13, 8'h14, 8'h14, 8'h14, 8'h14};
  logic [7:0] rv [8] = '{8'h20, 8'h1F, 8'h06, 8'h03, 8'h01, 8'h42, 8'h03, 8'h44};
  logic [13:0] re [8] = '{14'h2008, 14'h1F08, 14'h1FC8, 14'h1F68, 14'h1F61,
    14'h1F6A, 14'h1F63, 14'h1F6C};
  rca_host host (.clk(ref_clk), .sdaBus(sdaBus), .scl(scl), .sdaDrv(sdaDrv));
  rca_control #(.UNIQUE_ID(UID), .PROG_CYCLES(20)) dut (.ref_clk, .rstn,
    .sclIn(scl), .sdaIn(sdaBus), .sdaOut, .sdaOe, .onBattery, .rtcTime,
    .analogTrimCode, .digitalTrim, .backupBusDisable, .supplySwitchPolicy,
    .resetThreshold, .progBusy, .rtcWrite, .rtcWriteStrobe);
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic summarize();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic fin);
    host.start();
    host.xfer(RCA_SEL_CCR, rx, ak);
    host.xfer(a, rx, ak);
    host.xfer(d, rx, ak);
    if (fin) begin
      host.stop();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host.start();
    host.xfer(RCA_SEL_CCR, rx, ak);
    host.xfer(a, rx, ak);
    host.start();
    host.xfer(RCA_SEL_CCR | 8'h01, rx, ak);
    host.xfer(8'hFF, rx, ak);
    host.stop();
  endtask : rd
  task automatic en();
    wr(RCA_ADDR_STATUS, RCA_CMD_WEL, 1'b1);
    wr(RCA_ADDR_STATUS, RCA_CMD_REGISTER_WRITE_LATCH, 1'b1);
  endtask : en
  task automatic prog();
    int i;
    logic b;
    b = 1'b0;
    for (i = 0; i < 400 && !(b && progBusy === 1'b0); i++) begin
      b |= (progBusy === 1'b1);
      @(posedge ref_clk);
    end
    if (i == 400) begin
      n_errors++;
      summarize();
    end
  endtask : prog
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk({sdaOe, progBusy, rtcWriteStrobe, outs}, {3'b100, 14'h0008});
    for (int k = 0; k < 8; k++) begin
      en();
      wr(ra[k], rv[k], 1'b1);
      prog();
      chk(outs, re[k]);
      rd(ra[k]);
      chk(rx, rv[k]);
    end
    $display("rows done");
    wr(RCA_ADDR_ATR, 8'h2A, 1'b1);
    rd(RCA_ADDR_ATR);
    chk(rx, 8'h1F);
    en();
    wr(RCA_ADDR_STATUS, RCA_CMD_CLEAR, 1'b1);
    rd(RCA_ADDR_STATUS);
    chk(rx[2:1], 2'b00);
    wr(RCA_ADDR_ATR, 8'h2A, 1'b1);
    rd(RCA_ADDR_ATR);
    chk(rx, 8'h1F);
    $display("refusal done");
    wr(RCA_ADDR_STATUS, RCA_CMD_WEL, 1'b1);
    rd(RCA_ADDR_STATUS);
    chk(rx[2:1], 2'b01);
    wr(RCA_ADDR_STATUS, RCA_CMD_REGISTER_WRITE_LATCH, 1'b1);
    rd(RCA_ADDR_STATUS);
    chk(rx[2:1], 2'b11);
    wr(RCA_ADDR_ATR, 8'h2A, 1'b0);
    wr(RCA_ADDR_ATR, 8'h2B, 1'b1);
    prog();
    rd(RCA_ADDR_ATR);
    chk(rx, 8'h2B);
    rd(RCA_ADDR_STATUS);
    chk(rx[2], 1'b0);
    en();
    wr(8'h18, 8'hFF, 1'b1);
    rd(RCA_ADDR_ATR);
    chk(outs, 14'h2B6C);
    en();
    wr(RCA_ADDR_ID_LO, 8'h55, 1'b1);
    rd(RCA_ADDR_ID_LO);
    chk(rx, UID[7:0]);
    rd(RCA_ADDR_ID_HI);
    chk(rx, UID[63:56]);
    $display("latch done");
    // clock bytes, strobe can fire inside the stop
    en();
    host.start();
    host.xfer(RCA_SEL_CCR, rx, ak);
    host.xfer(RCA_ADDR_RTC_LO, rx, ak);
    for (int k = 1; k < 9; k++) begin
      host.xfer(8'(k), rx, ak);
    end
    fork
      host.stop();
      for (j = 0; j < 60 && rtcWriteStrobe !== 1'b1; j++) begin
        @(negedge ref_clk);
      end
    join
    if (j == 60) begin
      n_errors++;
      summarize();
    end
    chk(rtcWrite, 56'h07060504030201);
    en();
    wr(RCA_ADDR_ALM0, 8'h85, 1'b1);
    prog();
    en();
    wr(RCA_ADDR_ALM1, 8'h85, 1'b1);
    prog();
    en();
    wr(RCA_ADDR_INT, 8'h60, 1'b1);
    prog();
    rtcTime <= 56'h00000000000305;
    rd(RCA_ADDR_STATUS);
    chk(rx[6:5], 2'b11);
    rd(RCA_ADDR_STATUS);
    chk(rx[6:5], 2'b00);
    en();
    wr(RCA_ADDR_INT, 8'hE0, 1'b1);
    prog();
    for (int k = 0; k < 2; k++) begin
      rtcTime <= 56'h00000000000306;
      repeat (8) @(posedge ref_clk);
      rtcTime <= 56'h00000000000305;
      rd(RCA_ADDR_STATUS);
      chk(rx[6:5], 2'b01);
    end
    $display("alarm done");
    en();
    wr(RCA_ADDR_PWR, 8'hC4, 1'b1);
    prog();
    onBattery <= 1'b1;
    host.start();
    host.xfer(RCA_SEL_CCR, rx, ak);
    host.stop();
    chk(ak, 1'b1);
    onBattery <= 1'b0;
    rd(RCA_ADDR_PWR);
    chk({rx, outs}, {8'hC4, 14'h2B7C});
    $display("backup done");
    summarize();
  end
endmodule : tb_top
